// >>> design/dcm_top.sv
/*
  Clock monitor and oscillator control: control register with gated source
  select and monitor enable, monitor flag with read-then-write clear, failover,
  interrupt status/mask, and the oscillator control word.
  Assumes clock pins are sampled at 40 MHz and the register master keeps the
  one-cycle strobe protocol; loop filter strobes come from logic on clock.
*/
`timescale 1ns/100ps
module dcm_top (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [dcm_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [dcm_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [dcm_pkg::DATA_W-1:0] bus_rdata,
  input wire logic int_base_pin,
  input wire logic ext_ref_pin,
  input wire logic ext_clk_pin,
  input wire logic int_ref_pin,
  input wire logic int_filter_stable_pin,
  input wire logic ext_settled_pin,
  input wire dcm_pkg::dcm_lf_t loop_filter,
  input wire logic ring_tick,
  output logic osc_clk_sel,
  output logic timebase_sel,
  output logic ext_slow_opt,
  output dcm_pkg::dcm_dco_t dco,
  output logic irq
);

  localparam int NSYNC = 6;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; levels from the second stage, edge detect on the second and third stages
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] sync3_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= {ext_settled_pin, int_filter_stable_pin, int_ref_pin, ext_clk_pin,
                  ext_ref_pin, int_base_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  wire logic int_fall = sync3_q[0] && !sync2_q[0];
  wire logic ext_ref_low = !sync2_q[1];
  wire logic ext_fall = sync3_q[2] && !sync2_q[2];
  wire logic int_ref_low = !sync2_q[3];
  wire logic int_filt_ok = sync2_q[4];
  wire logic ext_settled = sync2_q[5];

  ////////////////////////////////////////////////////////////////////////
  // activity detectors, one per clock source
  logic int_inactive;
  logic ext_inactive;

  dcm_activity #(.MISS_LIMIT(dcm_pkg::MISS_LIMIT)) u_int_act (
    .clock(clock),
    .sys_rst(sys_rst),
    .ref_low(ext_ref_low),
    .mon_fall(int_fall),
    .inactive(int_inactive)
  );

  dcm_activity #(.MISS_LIMIT(dcm_pkg::MISS_LIMIT)) u_ext_act (
    .clock(clock),
    .sys_rst(sys_rst),
    .ref_low(int_ref_low),
    .mon_fall(ext_fall),
    .inactive(ext_inactive)
  );

  ////////////////////////////////////////////////////////////////////////
  // control state
  logic mon_en_q;
  logic sel_q;
  logic ext_on_q;
  logic int_on_q;
  logic flag_q;
  logic mie_q;
  logic armed_q;
  logic ext_slow_q;
  logic int_inact_q;
  logic ext_inact_q;
  logic [dcm_pkg::IRQ_W-1:0] stat_q;
  logic [dcm_pkg::IRQ_W-1:0] mask_q;
  logic [dcm_pkg::DATA_W-1:0] rdata_q;

  // stable flags drop when the generator is off or its clock looks dead
  wire logic int_stable = int_on_q && int_filt_ok && !int_inactive;
  wire logic ext_stable = ext_on_q && ext_settled && !ext_inactive;

  // register decode
  wire logic ctrl_wr = bus_wr && (bus_addr == dcm_pkg::OFS_CTRL);
  wire logic ctrl_rd = bus_rd && (bus_addr == dcm_pkg::OFS_CTRL);
  wire logic stat_wr = bus_wr && (bus_addr == dcm_pkg::OFS_IRQ_STAT);
  wire logic mask_wr = bus_wr && (bus_addr == dcm_pkg::OFS_IRQ_MASK);
  wire logic opt_wr = bus_wr && (bus_addr == dcm_pkg::OFS_OPT);

  // source select write only if the target clock is on and stable
  wire logic w_sel = bus_wdata[dcm_pkg::B_SEL];
  wire logic sel_ok = w_sel ? ext_stable : int_stable;
  wire logic mon_ok = int_stable && ext_stable;

  // failover only while the monitor runs
  wire logic fail_int = mon_en_q && int_inactive;
  wire logic fail_ext = mon_en_q && ext_inactive && !int_inactive;

  // new inactivity events
  wire logic int_off_ev = int_inactive && !int_inact_q;
  wire logic ext_off_ev = ext_inactive && !ext_inact_q;
  wire logic flag_set = mon_en_q && (int_off_ev || ext_off_ev);
  wire logic flag_clr = ctrl_wr && armed_q && !bus_wdata[dcm_pkg::B_FLAG];
  wire logic [dcm_pkg::IRQ_W-1:0] ev = {ext_off_ev, int_off_ev, flag_set};

  wire logic sel_d = fail_int ? 1'b1 : fail_ext ? 1'b0 :
                     (ctrl_wr && sel_ok) ? w_sel : sel_q;
  // enabling is gated, clearing is not, and loss of stability never clears
  wire logic mon_en_d = !ctrl_wr ? mon_en_q :
                        bus_wdata[dcm_pkg::B_MON_EN] ? (mon_en_q || mon_ok) : 1'b0;
  // set beats clear in the same cycle
  wire logic flag_d = flag_set || (flag_q && !flag_clr);

  ////////////////////////////////////////////////////////////////////////
  // control register and read-then-write arming of the flag clear
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mon_en_q <= dcm_pkg::CTRL_RST[dcm_pkg::B_MON_EN];
      sel_q <= dcm_pkg::CTRL_RST[dcm_pkg::B_SEL];
      ext_on_q <= dcm_pkg::CTRL_RST[dcm_pkg::B_EXT_ON];
      int_on_q <= dcm_pkg::CTRL_RST[dcm_pkg::B_INT_ON];
      flag_q <= dcm_pkg::CTRL_RST[dcm_pkg::B_FLAG];
      mie_q <= dcm_pkg::CTRL_RST[dcm_pkg::B_MIE];
      armed_q <= 1'b0;
    end
    else
    begin
      mon_en_q <= mon_en_d;
      sel_q <= sel_d;
      flag_q <= flag_d;
      if (ctrl_wr)
      begin
        ext_on_q <= bus_wdata[dcm_pkg::B_EXT_ON];
        int_on_q <= bus_wdata[dcm_pkg::B_INT_ON];
        mie_q <= bus_wdata[dcm_pkg::B_MIE];
      end
      // a read that sees the flag arms, even alongside a control write; any other control write disarms
      if (ctrl_rd && flag_q)
        armed_q <= 1'b1;
      else if (ctrl_wr)
        armed_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status (write one to clear, set wins), mask, option, edges
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stat_q <= '0;
      mask_q <= dcm_pkg::MASK_RST;
      ext_slow_q <= 1'b0;
      int_inact_q <= 1'b0;
      ext_inact_q <= 1'b0;
    end
    else
    begin
      stat_q <= ev | (stat_q & ~(stat_wr ? bus_wdata[dcm_pkg::IRQ_W-1:0] : '0));
      if (mask_wr)
        mask_q <= bus_wdata[dcm_pkg::IRQ_W-1:0];
      if (opt_wr)
        ext_slow_q <= bus_wdata[dcm_pkg::B_EXT_SLOW];
      int_inact_q <= int_inactive;
      ext_inact_q <= ext_inactive;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // oscillator control word
  logic [7:0] stage;
  logic [3:0] div_raw;

  dcm_dco u_dco (
    .clock(clock),
    .sys_rst(sys_rst),
    .lf(loop_filter),
    .ring_tick(ring_tick),
    .stage(stage),
    .div_raw(div_raw),
    .dco(dco)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered so data stand the cycle after the strobe
  wire logic [dcm_pkg::DATA_W-1:0] ctrl_view = {mie_q, flag_q, int_on_q, int_stable,
                                                ext_on_q, ext_stable, sel_q, mon_en_q};
  wire logic [dcm_pkg::DATA_W-1:0] rd_mux =
    (bus_addr == dcm_pkg::OFS_CTRL) ? ctrl_view :
    (bus_addr == dcm_pkg::OFS_IRQ_STAT) ? {5'h00, stat_q} :
    (bus_addr == dcm_pkg::OFS_IRQ_MASK) ? {5'h00, mask_q} :
    (bus_addr == dcm_pkg::OFS_STAGE) ? stage :
    (bus_addr == dcm_pkg::OFS_DIV) ? {4'h0, div_raw} :
    (bus_addr == dcm_pkg::OFS_OPT) ? {7'h00, ext_slow_q} : 8'h00;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else
      rdata_q <= bus_rd ? rd_mux : 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs; timebase follows the external-on bit unless failover forces it
  assign bus_rdata = rdata_q;
  assign osc_clk_sel = sel_q;
  assign timebase_sel = fail_int ? 1'b1 : fail_ext ? 1'b0 : ext_on_q;
  assign ext_slow_opt = ext_slow_q;
  assign irq = (flag_q && mie_q) || |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_sel_gated;
    @(posedge clock) disable iff (sys_rst)
      ctrl_wr && !sel_ok && !fail_int && !fail_ext |=> sel_q == $past(sel_q);
  endproperty
  a_sel_gated: assert property (p_sel_gated) else $error("select changed while gated");

  property p_mon_gated;
    @(posedge clock) disable iff (sys_rst) !mon_en_q && !mon_ok |=> !mon_en_q;
  endproperty
  a_mon_gated: assert property (p_mon_gated) else $error("monitor enabled while unstable");

  property p_flag_keep;
    @(posedge clock) disable iff (sys_rst)
      flag_q && !(ctrl_wr && armed_q && !bus_wdata[dcm_pkg::B_FLAG]) |=> flag_q;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag cleared without armed zero");

  property p_mon_hold;
    @(posedge clock) disable iff (sys_rst) mon_en_q && !ctrl_wr |=> mon_en_q;
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("monitor enable dropped");

  property p_failover;
    @(posedge clock) disable iff (sys_rst)
      mon_en_q && int_inactive |=> osc_clk_sel ##0 $past(timebase_sel);
  endproperty
  a_failover: assert property (p_failover) else $error("no failover to external");

  property p_irq;
    @(posedge clock) disable iff (sys_rst) flag_q && mie_q |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_ring;
    @(posedge clock) disable iff (sys_rst)
      dco.ring_delays >= dcm_pkg::RING_BASE && dco.ring_delays[0];
  endproperty
  a_ring: assert property (p_ring) else $error("ring length out of range");

  property p_failover_ext;
    @(posedge clock) disable iff (sys_rst)
      mon_en_q && ext_inactive && !int_inactive |=> !osc_clk_sel && !$past(timebase_sel);
  endproperty
  a_failover_ext: assert property (p_failover_ext) else $error("no failover to internal");

  property p_flag_clear;
    @(posedge clock) disable iff (sys_rst)
      ctrl_wr && armed_q && !bus_wdata[dcm_pkg::B_FLAG] && !flag_set |=> !flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag kept after armed zero");

endmodule // dcm_top

// >>> design/dcm_pkg.sv
/*
  Shared constants and types for the clock monitor and oscillator control block:
  register offsets, bit positions, reset values, oscillator limits, carrier structs.
  Assumes an 8-bit register port with a 4-bit word address.
*/
package dcm_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_STAGE = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_DIV = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_OPT = 4'h5;

  // clockgen_control_reg bit positions
  localparam int B_MON_EN = 0;
  localparam int B_SEL = 1;
  localparam int B_EXT_STB = 2;
  localparam int B_EXT_ON = 3;
  localparam int B_INT_STB = 4;
  localparam int B_INT_ON = 5;
  localparam int B_FLAG = 6;
  localparam int B_MIE = 7;

  // interrupt status / mask bit positions
  localparam int IRQ_W = 3;
  localparam int I_MON = 0;
  localparam int I_INT_OFF = 1;
  localparam int I_EXT_OFF = 2;

  // option_register_two bit position
  localparam int B_EXT_SLOW = 0;

  // reset values: internal generator on, internal clock selected
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h20;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [7:0] STAGE_RST = 8'h00;
  localparam logic [3:0] DIV_RST = 4'h0;

  // oscillator limits
  localparam logic [3:0] DIV_MAX_EFF = 4'h9;
  localparam logic [3:0] DIV_TOP = 4'hF;
  localparam logic [7:0] STEP_COARSE = 8'h20;
  localparam logic [7:0] STEP_FINE = 8'h01;
  localparam logic [4:0] RING_BASE = 5'h11;
  localparam int FRAC_W = 5;

  // activity detector: consecutive empty low phases before inactive
  localparam int MISS_LIMIT = 2;

  typedef struct packed {
    logic [3:0] div_code;
    logic [4:0] ring_delays;
    logic ring_long;
  } dcm_dco_t;

  typedef struct packed {
    logic up;
    logic down;
    logic coarse;
  } dcm_lf_t;

endpackage

// >>> design/dcm_activity.sv
/*
  Clock activity detector: flags a monitored clock inactive when no falling edge
  of it is seen during MISS_LIMIT consecutive low phases of a reference.
  Assumes both inputs are already synchronised to clock.
*/
`timescale 1ns/100ps
module dcm_activity #(
  parameter int MISS_LIMIT = dcm_pkg::MISS_LIMIT
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ref_low,
  input wire logic mon_fall,
  output logic inactive
);

  initial
  begin
    if (MISS_LIMIT < 1 || MISS_LIMIT > 15)
      $error("dcm_activity: MISS_LIMIT out of range");
  end

  logic ref_low_q;
  logic seen_q;
  logic [3:0] miss_q;
  logic inactive_q;
  wire logic phase_end = ref_low_q && !ref_low;
  wire logic hit = mon_fall && ref_low;

  ////////////////////////////////////////////////////////////////////////
  // count empty low phases; a hit clears at once
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ref_low_q <= 1'b0;
      seen_q <= 1'b0;
      miss_q <= 4'h0;
      inactive_q <= 1'b0;
    end
    else
    begin
      ref_low_q <= ref_low;
      seen_q <= phase_end ? 1'b0 : (seen_q | hit);
      if (hit)
      begin
        miss_q <= 4'h0;
        inactive_q <= 1'b0;
      end
      else if (phase_end && !seen_q)
      begin
        miss_q <= (miss_q == 4'(MISS_LIMIT)) ? miss_q : miss_q + 4'h1;
        inactive_q <= inactive_q | (miss_q == 4'(MISS_LIMIT - 1));
      end
    end
  end

  assign inactive = inactive_q;

  property p_clear_on_hit;
    @(posedge clock) disable iff (sys_rst) hit |=> !inactive;
  endproperty
  a_clear_on_hit: assert property (p_clear_on_hit) else $error("inactive not cleared by edge");

endmodule // dcm_activity

// >>> design/dcm_dco.sv
/*
  Oscillator control word: stage control value and divider code driven by the
  loop filter, ring length and fractional long-ring selection.
  Assumes loop filter strobes and ring ticks are single pulses on clock.
*/
`timescale 1ns/100ps
module dcm_dco (
  input wire logic clock,
  input wire logic sys_rst,
  input wire dcm_pkg::dcm_lf_t lf,
  input wire logic ring_tick,
  output logic [7:0] stage,
  output logic [3:0] div_raw,
  output dcm_pkg::dcm_dco_t dco
);

  logic [7:0] stage_q;
  logic [3:0] div_q;
  logic [dcm_pkg::FRAC_W-1:0] phase_q;
  dcm_pkg::dcm_dco_t dco_q;

  // coarse steps move one ring-length unit
  wire logic [7:0] step = lf.coarse ? dcm_pkg::STEP_COARSE : dcm_pkg::STEP_FINE;
  wire logic [8:0] sum = {1'b0, stage_q} + {1'b0, step};
  wire logic [8:0] dif = {1'b0, stage_q} - {1'b0, step};
  wire logic carry = lf.up && sum[8];
  wire logic borrow = lf.down && !lf.up && dif[8];
  wire logic [3:0] div_eff = (div_q > dcm_pkg::DIV_MAX_EFF) ? dcm_pkg::DIV_MAX_EFF : div_q;
  wire logic [4:0] delays = dcm_pkg::RING_BASE + {1'b0, stage_q[7:5], 1'b0};
  wire logic longer = phase_q < stage_q[4:0];

  ////////////////////////////////////////////////////////////////////////
  // divider code moves only on carry or borrow of the stage value
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stage_q <= dcm_pkg::STAGE_RST;
      div_q <= dcm_pkg::DIV_RST;
      phase_q <= '0;
      // stage zero means the shortest ring, so the word never shows an illegal length
      dco_q <= '{div_code: dcm_pkg::DIV_RST, ring_delays: dcm_pkg::RING_BASE, ring_long: 1'b0};
    end
    else
    begin
      if (lf.up)
        stage_q <= sum[7:0];
      else if (lf.down)
        stage_q <= dif[7:0];
      if (carry && div_q != dcm_pkg::DIV_TOP)
        div_q <= div_q + 4'h1;
      else if (borrow && div_q != 4'h0)
        div_q <= div_q - 4'h1;
      if (ring_tick)
        phase_q <= phase_q + 5'h01;
      dco_q <= '{div_code: div_eff, ring_delays: delays, ring_long: longer};
    end
  end

  assign stage = stage_q;
  assign div_raw = div_q;
  assign dco = dco_q;

  property p_div_on_carry;
    @(posedge clock) disable iff (sys_rst)
      !carry && !borrow |=> div_q == $past(div_q);
  endproperty
  a_div_on_carry: assert property (p_div_on_carry) else $error("divider moved without carry");

  property p_div_sat;
    @(posedge clock) disable iff (sys_rst) dco.div_code <= dcm_pkg::DIV_MAX_EFF;
  endproperty
  a_div_sat: assert property (p_div_sat) else $error("divider code beyond saturation");

  property p_coarse_step;
    @(posedge clock) disable iff (sys_rst)
      lf.up && lf.coarse |=> stage_q == $past(stage_q) + dcm_pkg::STEP_COARSE;
  endproperty
  a_coarse_step: assert property (p_coarse_step) else $error("coarse step wrong");

endmodule // dcm_dco

// >>> test/tb.sv
/*
  Self-checking bench for the clock monitor and oscillator control block:
  register access, gated select and monitor enable, flag clear, failover,
  interrupt status and mask, and the oscillator control word.
  Assumes the design checks its own properties inside its files.
*/
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [dcm_pkg::ADDR_W-1:0] bus_addr = '0;
  logic [dcm_pkg::DATA_W-1:0] bus_wdata = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [dcm_pkg::DATA_W-1:0] bus_rdata;
  logic int_base_pin = 1'b0;
  logic ext_ref_pin = 1'b0;
  logic ext_clk_pin = 1'b0;
  logic int_ref_pin = 1'b0;
  logic int_filter_stable_pin = 1'b0;
  logic ext_settled_pin = 1'b0;
  dcm_pkg::dcm_lf_t loop_filter = '0;
  logic ring_tick = 1'b0;
  logic osc_clk_sel, timebase_sel, ext_slow_opt, irq;
  dcm_pkg::dcm_dco_t dco;
  int fail_count = 0;
  int n_checks = 0;
  logic int_run = 1'b1;
  logic ext_run = 1'b1;
  logic [7:0] pin_cnt = 8'h00;
  logic [7:0] rd;
  int stage_m = 0;
  int div_m = 0;
  int phase_m = 0;
  logic [7:0] rst_exp [6] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  dcm_top i_dut (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .int_base_pin(int_base_pin), .ext_ref_pin(ext_ref_pin), .ext_clk_pin(ext_clk_pin),
    .int_ref_pin(int_ref_pin), .int_filter_stable_pin(int_filter_stable_pin),
    .ext_settled_pin(ext_settled_pin), .loop_filter(loop_filter), .ring_tick(ring_tick),
    .osc_clk_sel(osc_clk_sel), .timebase_sel(timebase_sel), .ext_slow_opt(ext_slow_opt),
    .dco(dco), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // clock and pin activity
  always #12.5 clock = ~clock;

  // base clocks toggle every 2 cycles, references every 16 so each low phase sees edges
  always @(posedge clock)
  begin
    pin_cnt <= pin_cnt + 8'h01;
    if (int_run && pin_cnt[0]) int_base_pin <= ~int_base_pin;
    if (ext_run && pin_cnt[0]) ext_clk_pin <= ~ext_clk_pin;
    if (pin_cnt[3:0] == 4'h0)
    begin
      ext_ref_pin <= ~ext_ref_pin;
      int_ref_pin <= ~int_ref_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tasks
  task automatic stop_test();
    if (fail_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge clock);
    bus_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic bus_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge clock);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic read_chk(input logic [3:0] a, input logic [7:0] e);
    bus_read(a, rd);
    `CHK(rd, e);
  endtask

  // one loop filter correction; behavioural model follows the stage and divider
  task automatic lf_op(input bit up, input bit dn, input bit crs, input bit tk);
    int step;
    step = crs ? 32 : 1;
    @(posedge clock);
    loop_filter <= '{up: up, down: dn, coarse: crs};
    ring_tick <= tk;
    @(posedge clock);
    loop_filter <= '0;
    ring_tick <= 1'b0;
    if (up)
    begin
      if (stage_m + step > 255 && div_m < 15) div_m++;
      stage_m = (stage_m + step) & 255;
    end
    else if (dn)
    begin
      if (stage_m < step && div_m > 0) div_m--;
      stage_m = (stage_m - step) & 255;
    end
    if (tk) phase_m = (phase_m + 1) & 31;
    settle(2);
    `CHK(dco.div_code, 4'(div_m > 9 ? 9 : div_m));
    `CHK(dco.ring_delays, 5'(17 + 2 * (stage_m >> 5)));
    `CHK(dco.ring_long, 1'(phase_m < (stage_m & 31)));
    read_chk(dcm_pkg::OFS_STAGE, 8'(stage_m));
    read_chk(dcm_pkg::OFS_DIV, 8'(div_m));
  endtask

  // bounded wait on the interrupt line; running out ends the run
  task automatic wait_irq(input logic v);
    int i;
    for (i = 0; i < 300 && irq !== v; i++) settle(1);
    if (irq !== v)
    begin
      fail_count++;
      $display("MISMATCH t=%0t interrupt wait timed out", $time);
      stop_test();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int i;
    void'($urandom(27));
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++) read_chk(4'(i), rst_exp[i]);
    `CHK(irq, 1'b0);
    // unmapped place reads zero and ignores writes
    bus_write(4'hF, 8'hFF);
    read_chk(4'hF, 8'h00);
    bus_write(dcm_pkg::OFS_OPT, 8'h01);
    read_chk(dcm_pkg::OFS_OPT, 8'h01);
    `CHK(ext_slow_opt, 1'b1);
    int_filter_stable_pin <= 1'b1;
    ext_settled_pin <= 1'b1;
    settle(4);
    // external off: select and monitor enable are both refused
    bus_write(dcm_pkg::OFS_CTRL, 8'h23);
    read_chk(dcm_pkg::OFS_CTRL, 8'h30);
    // enable the wanted source, poll for stable, then switch
    bus_write(dcm_pkg::OFS_CTRL, 8'h28);
    for (i = 0; i < 50; i++)
    begin
      bus_read(dcm_pkg::OFS_CTRL, rd);
      if (rd[dcm_pkg::B_EXT_STB] === 1'b1) break;
    end
    `CHK(rd, 8'h3C);
    bus_write(dcm_pkg::OFS_CTRL, 8'h2A);
    settle(1);
    `CHK(osc_clk_sel, 1'b1);
    bus_write(dcm_pkg::OFS_CTRL, 8'h28);
    settle(1);
    `CHK(osc_clk_sel, 1'b0);
    `CHK(timebase_sel, 1'b1);
    // monitor on, then its interrupt enable, in that order
    bus_write(dcm_pkg::OFS_CTRL, 8'h29);
    bus_write(dcm_pkg::OFS_CTRL, 8'hA9);
    read_chk(dcm_pkg::OFS_CTRL, 8'hBD);
    `CHK(irq, 1'b0);
    // internal base clock stops: flag, failover to external
    int_run <= 1'b0;
    wait_irq(1'b1);
    settle(4);
    `CHK(osc_clk_sel, 1'b1);
    `CHK(timebase_sel, 1'b1);
    read_chk(dcm_pkg::OFS_CTRL, 8'hEF);
    read_chk(dcm_pkg::OFS_IRQ_STAT, 8'h03);
    // writing one, or zero without a fresh read, leaves the flag
    bus_write(dcm_pkg::OFS_CTRL, 8'hEF);
    bus_write(dcm_pkg::OFS_CTRL, 8'hAF);
    settle(1);
    `CHK(irq, 1'b1);
    read_chk(dcm_pkg::OFS_CTRL, 8'hEF);
    bus_write(dcm_pkg::OFS_CTRL, 8'hAF);
    read_chk(dcm_pkg::OFS_CTRL, 8'hAF);
    `CHK(irq, 1'b0);
    // status bits reach the line only through the mask
    bus_write(dcm_pkg::OFS_IRQ_MASK, 8'h02);
    wait_irq(1'b1);
    bus_write(dcm_pkg::OFS_IRQ_STAT, 8'h02);
    wait_irq(1'b0);
    read_chk(dcm_pkg::OFS_IRQ_STAT, 8'h01);
    bus_write(dcm_pkg::OFS_IRQ_MASK, 8'h01);
    wait_irq(1'b1);
    bus_write(dcm_pkg::OFS_IRQ_STAT, 8'h01);
    wait_irq(1'b0);
    read_chk(dcm_pkg::OFS_IRQ_STAT, 8'h00);
    // internal clock back: monitor stays on, external stays selected and on
    int_run <= 1'b1;
    settle(100);
    read_chk(dcm_pkg::OFS_CTRL, 8'hBF);
    // external clock stops: failover to internal, external event logged
    ext_run <= 1'b0;
    wait_irq(1'b1);
    settle(4);
    `CHK(osc_clk_sel, 1'b0);
    `CHK(timebase_sel, 1'b0);
    read_chk(dcm_pkg::OFS_IRQ_STAT, 8'h05);
    read_chk(dcm_pkg::OFS_CTRL, 8'hF9);
    ext_run <= 1'b1;
    settle(100);
    bus_write(dcm_pkg::OFS_CTRL, 8'hBF);
    bus_write(dcm_pkg::OFS_IRQ_STAT, 8'h05);
    wait_irq(1'b0);
    bus_write(dcm_pkg::OFS_CTRL, 8'hBE);
    bus_write(dcm_pkg::OFS_CTRL, 8'hBC);
    bus_write(dcm_pkg::OFS_CTRL, 8'hA0);
    bus_write(dcm_pkg::OFS_CTRL, 8'hA2);
    settle(2);
    `CHK(osc_clk_sel, 1'b0);
    `CHK(timebase_sel, 1'b0);
    read_chk(dcm_pkg::OFS_CTRL, 8'hB0);
    // loop filter: mostly up to saturate the divider, then mostly down to bring it back down
    for (i = 0; i < 600; i++)
      lf_op(i < 300 ? ($urandom % 8 != 0) : ($urandom % 8 == 0), $urandom % 2,
            $urandom % 4 != 0, $urandom % 2);
    stop_test();
  end
endmodule // tb
